// ---- msr_pkg.sv ----
// Constants, register map and state type of the metering status registers.
// Assumes one 250 MHz clock and a plain strobe-based register port.
`default_nettype none

package msr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] AUTOCAL_STATUS_ADDR = 12'h04C0;
  localparam logic [11:0] EVENT_STATUS_ADDR   = 12'h04C1;
  localparam logic [11:0] CHIP_STATUS_ADDR    = 12'h04C2;
  localparam logic [11:0] IRQ_PENDING_ADDR    = 12'h04C4;
  localparam logic [11:0] IRQ_MASK_ADDR       = 12'h04C5;

  localparam logic [15:0] REG_RESET_VALUE     = 16'h0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned NEW_RUN_READY_BIT   = 14;
  localparam int unsigned CONFIG_ERROR_BIT    = 13;
  localparam int unsigned NOT_DETECTED_BIT    = 12;
  localparam int unsigned RUN_TIMEOUT_BIT     = 3;
  localparam int unsigned RESULT_READY_BIT    = 1;
  localparam int unsigned COEFF_SHIFTED_BIT   = 0;

  localparam int unsigned CHAN_B_OVER_BIT     = 5;
  localparam int unsigned CHAN_A_OVER_BIT     = 4;
  localparam int unsigned SWELL_BIT           = 2;
  localparam int unsigned DIP_BIT             = 0;

  localparam int unsigned SERIAL_RESET_BIT    = 7;
  localparam int unsigned SERIAL_FAULT_LSB    = 4;
  localparam int unsigned INTERNAL_FAULT_LSB  = 0;

  localparam logic [15:0] AUTOCAL_VALID_MASK  = 16'h700B;
  localparam logic [15:0] EVENT_VALID_MASK    = 16'h0035;
  localparam logic [15:0] CHIP_VALID_MASK     = 16'h00FF;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned SECOND_TIME_S       = 1;
  localparam logic [27:0] SECOND_CYCLES       = 28'(CLK_HZ * SECOND_TIME_S);
  localparam int unsigned TIMEOUT_TIME_S      = 600;
  localparam logic [9:0]  TIMEOUT_SECONDS     = 10'(TIMEOUT_TIME_S / SECOND_TIME_S);
  localparam int unsigned ACCUM_TIME_S        = 8;
  localparam logic [9:0]  ACCUM_SECONDS       = 10'(ACCUM_TIME_S / SECOND_TIME_S);

  // ****************************************
  // Autocalibration sequencer
  // ****************************************
  typedef enum logic [1:0] {
    MSR_IDLE   = 2'b00,
    MSR_RUN    = 2'b01,
    MSR_HALT   = 2'b11,
    MSR_SETTLE = 2'b10
  } msr_state_e;

endpackage

`default_nettype wire

// ---- msr_status_regs.sv ----
// Status register bank: autocalibration flags, power-quality events, chip faults.
// Assumes all inputs synchronous to clk; event inputs are levels, copied into the event register every cycle.
//
// Our own choice: the address-and-strobe port.
`default_nettype none

module msr_status_regs
  import msr_pkg::*;
#(
  parameter logic [27:0] SEC_CYCLES = SECOND_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [11:0] addr,
  input  wire logic [15:0] wrData,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  output var  logic [15:0] rdData,
  output var  logic        irq,
  // Autocalibration engine
  input  wire logic        autocalEnable,
  input  wire logic        autocalRunDone,
  input  wire logic        autocalNotDetected,
  input  wire logic        autocalCoeffShifted,
  input  wire logic        autocalConfigError,
  output var  logic        autocalResultUpdate,
  // Metrology conditions
  input  wire logic        chanAOvercurrent,
  input  wire logic        chanBOvercurrent,
  input  wire logic        voltageSwell,
  input  wire logic        voltageDip,
  // Serial interface and core faults
  input  wire logic        serialIfReset,
  input  wire logic [2:0]  serialIfFault,
  input  wire logic [3:0]  internalFault,
  input  wire logic        softReset
);

  // ****************************************
  // Declarations
  // ****************************************
  msr_state_e  state;
  msr_state_e  next_state;
  logic [27:0] secDiv;
  logic        secTick;
  logic [9:0]  runSec;
  logic        runStart;
  logic        timeoutHit;
  logic        readyHit;
  logic        settleDone;
  logic [15:0] autocalStatus;
  logic [15:0] autocalSet;
  logic [15:0] eventStatus;
  logic [7:0]  chipStatus;
  logic [7:0]  chipSet;
  logic [7:0]  chipClr;
  logic [15:0] irqPending;
  logic [15:0] irqMask;
  logic [15:0] next_rdData;

  // ****************************************
  // Sequencer
  // ****************************************
  assign secTick    = (secDiv == SEC_CYCLES - 28'h000_0001);
  assign runStart   = (state == MSR_IDLE) && autocalEnable;
  // Run counter holds whole seconds already elapsed
  assign timeoutHit = (state == MSR_RUN) && secTick
                      && (runSec == TIMEOUT_SECONDS - 10'h001);
  assign readyHit   = (state == MSR_RUN) && secTick
                      && (runSec >= ACCUM_SECONDS - 10'h001);
  assign settleDone = (state == MSR_SETTLE) && secTick;

  always_comb
  begin
    next_state = state;
    unique case (state)
      MSR_IDLE:
      begin
        if (autocalEnable)
          next_state = MSR_RUN;
      end
      MSR_RUN:
      begin
        if (!autocalEnable)
          next_state = MSR_SETTLE;
        else if (autocalRunDone || timeoutHit)
          next_state = MSR_HALT;
      end
      MSR_HALT:
      begin
        if (!autocalEnable)
          next_state = MSR_SETTLE;
      end
      MSR_SETTLE:
      begin
        // Re-enable while settling waits for the ready point
        if (settleDone)
          next_state = MSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= MSR_IDLE;
    else
      state <= next_state;
  end

  // Divider restarts on every state change so each second is whole
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      secDiv <= 28'h000_0000;
    else if (next_state != state || secTick)
      secDiv <= 28'h000_0000;
    else if (state == MSR_RUN || state == MSR_SETTLE)
      secDiv <= secDiv + 28'h000_0001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      runSec <= 10'h000;
    else if (runStart)
      runSec <= 10'h000;
    else if (state == MSR_RUN && secTick)
      runSec <= runSec + 10'h001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      autocalResultUpdate <= 1'b0;
    else
      autocalResultUpdate <= readyHit;
  end

  // ****************************************
  // Autocalibration status
  // ****************************************
  always_comb
  begin
    autocalSet                    = 16'h0000;
    autocalSet[NOT_DETECTED_BIT]  = autocalNotDetected;
    autocalSet[RUN_TIMEOUT_BIT]   = timeoutHit;
    autocalSet[RESULT_READY_BIT]  = readyHit;
    autocalSet[COEFF_SHIFTED_BIT] = autocalCoeffShifted;
    autocalSet[NEW_RUN_READY_BIT] = settleDone;
    autocalSet[CONFIG_ERROR_BIT]  = autocalConfigError;
  end

  // Flags clear at the start of a new run; a set in that cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      autocalStatus <= REG_RESET_VALUE;
    else
      autocalStatus <= ((runStart ? 16'h0000 : autocalStatus) | autocalSet)
                       & AUTOCAL_VALID_MASK;
  end

  // ****************************************
  // Power-quality events
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      eventStatus <= REG_RESET_VALUE;
    else
    begin
      eventStatus                  <= 16'h0000;
      eventStatus[CHAN_B_OVER_BIT] <= chanBOvercurrent;
      eventStatus[CHAN_A_OVER_BIT] <= chanAOvercurrent;
      eventStatus[SWELL_BIT]       <= voltageSwell;
      eventStatus[DIP_BIT]         <= voltageDip;
    end
  end

  // ****************************************
  // Chip faults
  // ****************************************
  always_comb
  begin
    chipSet = {serialIfReset, serialIfFault, internalFault};
    chipClr = {softReset, {3{serialIfReset}}, {4{softReset}}};
  end

  // Sticky per bit; a new fault beats a clear in the same cycle
  for (genvar i = 0; i < 8; i++)
  begin : gChip
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        chipStatus[i] <= 1'b0;
      else if (chipSet[i])
        chipStatus[i] <= 1'b1;
      else if (chipClr[i])
        chipStatus[i] <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irqPending <= REG_RESET_VALUE;
    else if (wrEn && addr == IRQ_PENDING_ADDR)
      irqPending <= (irqPending & ~wrData) | autocalSet;
    else
      irqPending <= irqPending | autocalSet;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irqMask <= REG_RESET_VALUE;
    else if (wrEn && addr == IRQ_MASK_ADDR)
      irqMask <= wrData & AUTOCAL_VALID_MASK;
  end

  // Registered so the pin is glitch free; lags the status by one cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irqPending & irqMask);
  end

  // ****************************************
  // Read port
  // ****************************************
  // Writes to the three status addresses fall through: no decode
  always_comb
  begin
    next_rdData = 16'h0000;
    if (rdEn)
    begin
      unique case (addr)
        AUTOCAL_STATUS_ADDR: next_rdData = autocalStatus & AUTOCAL_VALID_MASK;
        EVENT_STATUS_ADDR:   next_rdData = eventStatus & EVENT_VALID_MASK;
        CHIP_STATUS_ADDR:    next_rdData = {8'h00, chipStatus};
        IRQ_PENDING_ADDR:    next_rdData = irqPending;
        IRQ_MASK_ADDR:       next_rdData = irqMask;
        default:             next_rdData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdData <= 16'h0000;
    else
      rdData <= next_rdData;
  end

endmodule

`default_nettype wire

// ---- msr_status_regs_sva.sv ----
// Checker for the status bank: read port timing, event bits, reserved bits.
// Assumes binding to msr_status_regs; sees only its ports.
`default_nettype none

module msr_status_regs_chk
  import msr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] addr,
  input wire logic        rdEn,
  input wire logic [15:0] rdData,
  input wire logic        irq,
  input wire logic        autocalResultUpdate,
  input wire logic        chanAOvercurrent,
  input wire logic        chanBOvercurrent,
  input wire logic        voltageSwell,
  input wire logic        voltageDip
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ********
  // Read port and result update pulse
  // ********
  // Condition latched one edge, read register one more
  property evt_p(int b, logic c);
    $past(rdEn) && $past(addr) == EVENT_STATUS_ADDR && $past(rst_n, 2)
      |-> rdData[b] == $past(c, 2);
  endproperty

  rd_idle_zero_a: assert property (!$past(rdEn) |-> rdData == 16'h0000)
    else $error("read data not zero outside read cycle");
  evt_rsvd_a: assert property ($past(rdEn) && $past(addr) == EVENT_STATUS_ADDR
    |-> (rdData & ~EVENT_VALID_MASK) == 16'h0000) else $error("event reserved bit set");
  chip_rsvd_a: assert property ($past(rdEn) && $past(addr) == CHIP_STATUS_ADDR
    |-> rdData[15:8] == 8'h00) else $error("chip reserved bit set");
  unmapped_rd_a: assert property ($past(rdEn) && $past(addr) == 12'h04C3
    |-> rdData == 16'h0000) else $error("unmapped read not zero");
  chan_b_over_a: assert property (evt_p(5, chanBOvercurrent))
    else $error("channel B overcurrent bit wrong");
  chan_a_over_a: assert property (evt_p(4, chanAOvercurrent))
    else $error("channel A overcurrent bit wrong");
  swell_flag_a: assert property (evt_p(2, voltageSwell))
    else $error("swell bit wrong");
  dip_flag_a: assert property (evt_p(0, voltageDip))
    else $error("dip bit wrong");
  upd_pulse_a: assert property ($rose(autocalResultUpdate) |=> !autocalResultUpdate [*8])
    else $error("result update not a lone pulse");

  cover property ($past(rdEn) && rdData != 16'h0000);
  cover property (autocalResultUpdate);
  cover property (irq);
endmodule

bind msr_status_regs msr_status_regs_chk chk (.clk, .rst_n, .addr, .rdEn, .rdData, .irq,
  .autocalResultUpdate, .chanAOvercurrent, .chanBOvercurrent, .voltageSwell, .voltageDip);

`default_nettype wire

// ---- msr_tb.sv ----
// Self-checking bench for the status register bank.
// Assumes msr_pkg; the second is shortened to 20 clock cycles.
`default_nettype none

module testbench import msr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 20;
  localparam logic [15:0] EV [4] = '{16'h0001, 16'h0004, 16'h0010, 16'h0020};
  logic        clk, rst_n, wrEn, rdEn, irq, softReset, serialIfReset;
  logic        autocalEnable, autocalRunDone, autocalNotDetected, autocalCoeffShifted;
  logic        autocalConfigError, autocalResultUpdate;
  logic        chanAOvercurrent, chanBOvercurrent, voltageSwell, voltageDip;
  logic [11:0] addr;
  logic [15:0] wrData, rdData;
  logic [2:0]  serialIfFault;
  logic [3:0]  internalFault;
  int          fails, n_compared, n;

  msr_status_regs #(.SEC_CYCLES(28'h000_0014)) dut (.clk, .rst_n, .addr, .wrData, .wrEn,
    .rdEn, .rdData, .irq, .autocalEnable, .autocalRunDone, .autocalNotDetected,
    .autocalCoeffShifted, .autocalConfigError, .autocalResultUpdate, .chanAOvercurrent,
    .chanBOvercurrent, .voltageSwell, .voltageDip, .serialIfReset, .serialIfFault,
    .internalFault, .softReset);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t %s got %h want %h", $time, w, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e, input string w);
    @(posedge clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chk(rdData, e, w);
  endtask

  // Bounded wait for the next result update pulse
  task automatic waitUpd();
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (autocalResultUpdate !== 1'b1 && n < 300);
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial
  begin
    {rst_n, wrEn, rdEn, softReset, serialIfReset, autocalEnable, autocalRunDone} = '0;
    {autocalNotDetected, autocalCoeffShifted, autocalConfigError, addr, wrData} = '0;
    {chanAOvercurrent, chanBOvercurrent, voltageSwell, voltageDip} = '0;
    {serialIfFault, internalFault, fails, n_compared} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) rd(12'h04C0 + 12'(a), 16'h0000, "reset value");
    for (int a = 0; a < 4; a++)
    begin
      wr(12'h04C0 + 12'(a), 16'hFFFF);
      rd(12'h04C0 + 12'(a), 16'h0000, "read-only write");
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      {chanBOvercurrent, chanAOvercurrent, voltageSwell, voltageDip} <= 4'b0001 << i;
      rd(EVENT_STATUS_ADDR, EV[i], "event set");
    end
    @(posedge clk);
    {chanBOvercurrent, chanAOvercurrent, voltageSwell, voltageDip} <= 4'h0;
    rd(EVENT_STATUS_ADDR, 16'h0000, "event clear");
    $display("test events done");
    @(posedge clk);
    {internalFault, serialIfFault} <= 7'h7F;
    @(posedge clk);
    {internalFault, serialIfFault} <= 7'h00;
    rd(CHIP_STATUS_ADDR, 16'h007F, "faults held");
    @(posedge clk);
    serialIfReset <= 1'b1;
    @(posedge clk);
    serialIfReset <= 1'b0;
    rd(CHIP_STATUS_ADDR, 16'h008F, "serial reset");
    @(posedge clk);
    softReset <= 1'b1;
    @(posedge clk);
    softReset <= 1'b0;
    rd(CHIP_STATUS_ADDR, 16'h0000, "soft reset");
    $display("test chip done");
    @(posedge clk);
    {autocalConfigError, autocalNotDetected, autocalCoeffShifted} <= 3'b111;
    @(posedge clk);
    {autocalConfigError, autocalNotDetected, autocalCoeffShifted} <= 3'b000;
    rd(AUTOCAL_STATUS_ADDR, 16'h3001, "autocal flags");
    chk({15'h0000, irq}, 16'h0000, "irq masked");
    wr(IRQ_MASK_ADDR, 16'h2000);
    rd(IRQ_MASK_ADDR, 16'h2000, "mask");
    chk({15'h0000, irq}, 16'h0001, "irq raised");
    wr(IRQ_PENDING_ADDR, 16'h2000);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0000, "irq cleared");
    @(posedge clk);
    autocalEnable <= 1'b1;
    waitUpd();
    chk(16'(n >= 8 * T && n <= 8 * T + 3), 16'h0001, "first result");
    waitUpd();
    chk(16'(n), 16'(T), "result period");
    rd(AUTOCAL_STATUS_ADDR, 16'h0002, "result ready");
    repeat (591 * T + 10) @(posedge clk);
    rd(AUTOCAL_STATUS_ADDR, 16'h000A, "run timeout");
    @(posedge clk);
    autocalEnable <= 1'b0;
    repeat (T + 5) @(posedge clk);
    rd(AUTOCAL_STATUS_ADDR, 16'h400A, "new run ready");
    // New run clears old flags; a finished run must stop result updates
    @(posedge clk);
    autocalEnable <= 1'b1;
    repeat (3) @(posedge clk);
    autocalRunDone <= 1'b1;
    @(posedge clk);
    autocalRunDone <= 1'b0;
    repeat (9 * T) @(posedge clk);
    rd(AUTOCAL_STATUS_ADDR, 16'h0000, "run done halts");
    $display("test autocal done");
    @(posedge clk);
    autocalEnable <= 1'b0;
    internalFault <= 4'h5;
    @(posedge clk);
    internalFault <= 4'h0;
    rd(CHIP_STATUS_ADDR, 16'h0005, "faults before reset");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(CHIP_STATUS_ADDR, 16'h0000, "hardware reset");
    $display("test hardware reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
